// [rtl/buck_pkg.sv]
// Shared constants and types of the buck converter supervisor.
// Assumes one 250 MHz clock and a phase-clock tick that arrives on a pin.
package buck_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the AXI4-Lite slave.
	localparam int unsigned  ADDR_W         = 5;
	localparam logic [4:0]   OFS_CTRL       = 5'h00;
	localparam logic [4:0]   OFS_STATUS     = 5'h04;
	localparam logic [4:0]   OFS_REF        = 5'h08;
	localparam logic [4:0]   OFS_OC_COUNT   = 5'h0c;
	localparam logic [1:0]   RESP_OKAY      = 2'h0;
	localparam logic [1:0]   RESP_SLVERR    = 2'h2;

	// Control register fields and reset values.
	localparam int unsigned  CTRL_FORCE_BIT = 0;
	localparam logic         CTRL_FORCE_RST = 1'h0;

	// Status register field positions.
	localparam int unsigned  ST_STATE_LSB   = 0;
	localparam int unsigned  ST_PG_BIT      = 4;
	localparam int unsigned  ST_OVL_BIT     = 5;
	localparam int unsigned  ST_OSC_BIT     = 6;
	localparam int unsigned  ST_ENOK_BIT    = 7;
	localparam int unsigned  ST_CODE_LSB    = 8;
	localparam int unsigned  ST_PH3_BIT     = 13;

	////////////////////////////////////////////////////////////////////////////
	// Synchroniser bank layout: bit position of each pin input.
	localparam int unsigned  SYNC_W         = 16;
	localparam int unsigned  SY_POR         = 0;
	localparam int unsigned  SY_EN          = 1;
	localparam int unsigned  SY_OC          = 2;
	localparam int unsigned  SY_OV          = 3;
	localparam int unsigned  SY_OVREF       = 4;
	localparam int unsigned  SY_UV          = 5;
	localparam int unsigned  SY_TICK        = 6;
	localparam int unsigned  SY_CODE_LSB    = 7;
	localparam int unsigned  SY_DEM_LSB     = 12;
	localparam int unsigned  SY_PH3         = 15;

	////////////////////////////////////////////////////////////////////////////
	// Sequencing counts, in phase-clock (switching) cycles.
	localparam logic [10:0]  SS_HIZ_END     = 11'h01f;   // Last of the first 32 cycles.
	localparam logic [10:0]  SS_LOW_END     = 11'h0b5;   // 32 plus 150 cycles, minus one.
	localparam logic [10:0]  SS_LAST        = 11'h7ff;   // The 2048th cycle.
	localparam logic [10:0]  OC_WAIT_LAST   = 11'h7ff;   // 2048 cycles of hiccup wait.

	// Voltage code decoding, reference level in millivolts.
	localparam logic [4:0]   CODE_OFF       = 5'h1f;
	localparam logic [10:0]  REF_TOP_MV     = 11'h73a;   // 1850 mV at code zero.
	localparam logic [10:0]  REF_STEP_MV    = 11'h019;   // 25 mV per code step.
	localparam logic [10:0]  RAMP_STEP_MV   = 11'h001;

	// Channel layout of the current-balance path.
	localparam int unsigned  NCH            = 3;
	localparam int unsigned  CUR_W          = 8;
	localparam int unsigned  ERR_W          = 9;
	localparam logic [8:0]   THIRD_MUL      = 9'h0ab;    // 171/512, close to one third.

	typedef enum logic [3:0] {
		ST_SHUT,
		ST_SS_HIZ,
		ST_SS_LOW,
		ST_SS_RAMP,
		ST_RUN,
		ST_OC_WAIT,
		ST_OV_CLAMP,
		ST_OV_HIZ
	} state_t;

endpackage

// [rtl/sync_if.sv]
// Carrier between the supervisor and its input synchroniser bank.
// Assumes both ends share the supervisor clock.
`timescale 1ns/1ps
interface sync_if #(parameter int unsigned W = 16);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport user (output raw, input clean);
	modport bank (input raw, output clean);
endinterface

// [rtl/input_sync.sv]
// Three-stage synchroniser bank for asynchronous pin inputs.
// Assumes each pin holds a level for several clock cycles.
`timescale 1ns/1ps
module input_sync import buck_pkg::*; #(
	parameter int unsigned W = SYNC_W
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_b,
	// Raw pins in, qualified levels out.
	sync_if.bank      sif
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_reg;

	// Only the second stage looks at the first, so metastability stays contained.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= sif.raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A change counts once stages two and three agree on it.
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					q_reg[g] <= 1'b0;
				end else if (s2_reg[g] == s3_reg[g]) begin
					q_reg[g] <= s3_reg[g];
				end
			end
		end
	endgenerate

	assign sif.clean = q_reg;

endmodule

// [rtl/buck_supervisor.sv]
// Supervisory sequencer of a multi-phase buck controller with an AXI4-Lite slave.
// Assumes analog comparators and the phase oscillator deliver their results as pins.
`timescale 1ns/1ps

// How it works
// RQ1 - Average current above the fixed reference trips an overcurrent shutdown anytime; the code trips it only in soft-start and running, not during overvoltage.
// RQ2 - Overcurrent shutdown puts every PWM output into high impedance.
// RQ3 - After overcurrent, stay high impedance while counting 2048 phase-clock cycles.
// RQ4 - The wait ends in a soft-start; success resumes normal switching.
// RQ5 - Overcurrent during an attempt repeats wait and attempt, without end.
// RQ6 - Code 11110 gives 1.100 V, each lower code 25 mV more, to 1.850 V.
// RQ7 - All-ones code forces shutdown; any other code starts up again.
// RQ8 - Output above 115 percent of reference drives all PWM outputs low at once.
// RQ9 - While clamping, output back at reference switches PWM to high impedance.
// RQ10 - Each new overvoltage clamps low again, alternating as long as it recurs.
// RQ11 - Overvoltage latches off switching until power-on reset or enable toggles.
// RQ12 - Undervoltage drops power good only, unlatched, no other effect.
// RQ13 - In shutdown all PWM outputs stay high impedance.
// RQ14 - No start before power-on reset is good; its comparator has hysteresis.
// RQ15 - Oscillator stays stopped until the enable input is above threshold.
// RQ16 - Outside circuit pulls enable pin low to disable, releases it to enable.
// RQ17 - Power good, enable high and a non-off code start soft-start immediately.
// RQ18 - Each channel current is compared with the active average to trim width.
// RQ19 - Soft-start: 32 cycles high impedance, about 150 low, then ramp from zero.
// RQ20 - An 11-bit phase-clock counter times soft-start; power good at cycle 2048.
// RQ21 - Comparator results and code pins are synchronised before use.
module buck_supervisor import buck_pkg::*; (
	// Clock and reset.
	input  wire logic                   CLK,
	input  wire logic                   RST_B,
	// Comparator and pin inputs, asynchronous to CLK.
	input  wire logic                   POR_OK,
	input  wire logic                   FREQ_SELECT_ENABLE_PIN,
	input  wire logic                   OC_TRIP,
	input  wire logic                   OV_TRIP,
	input  wire logic                   OV_AT_REF,
	input  wire logic                   UV_LOW,
	input  wire logic                   PHASE_TICK,
	input  wire logic [4:0]             VOLTAGE_CODE,
	input  wire logic [NCH-1:0]         PWM_DEMAND,
	input  wire logic                   PHASE3_SEL,
	// Sampled channel currents from the sampling logic on CLK.
	input  wire logic [NCH*CUR_W-1:0]   CH_CURRENT,
	// Converter outputs.
	output logic      [NCH-1:0]         PWM_OUT,
	output logic      [NCH-1:0]         PWM_OE,
	output logic                        POWER_GOOD,
	output logic                        OSC_RUN,
	output logic      [10:0]            REFERENCE_LEVEL,
	output logic      [NCH*ERR_W-1:0]   BALANCE_TRIM,
	// AXI4-Lite slave.
	input  wire logic [ADDR_W-1:0]      S_AXI_AWADDR,
	input  wire logic                   S_AXI_AWVALID,
	output logic                        S_AXI_AWREADY,
	input  wire logic [31:0]            S_AXI_WDATA,
	input  wire logic [3:0]             S_AXI_WSTRB,
	input  wire logic                   S_AXI_WVALID,
	output logic                        S_AXI_WREADY,
	output logic      [1:0]             S_AXI_BRESP,
	output logic                        S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0]      S_AXI_ARADDR,
	input  wire logic                   S_AXI_ARVALID,
	output logic                        S_AXI_ARREADY,
	output logic      [31:0]            S_AXI_RDATA,
	output logic      [1:0]             S_AXI_RRESP,
	output logic                        S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY
);

	////////////////////////////////////////////////////////////////////////////
	// Input qualification.

	sync_if #(.W(SYNC_W)) sif ();

	logic          por_s;
	logic          en_s;
	logic          oc_s;
	logic          ov_s;
	logic          ovref_s;
	logic          uv_s;
	logic          ph3_s;
	logic [4:0]    code_s;
	logic [NCH-1:0] dem_s;
	logic          tick_d_reg;
	logic          tick;

	// Every asynchronous pin goes through the bank before the sequencer sees it.
	assign sif.raw = {PHASE3_SEL, PWM_DEMAND, VOLTAGE_CODE, PHASE_TICK, UV_LOW,
		OV_AT_REF, OV_TRIP, OC_TRIP, FREQ_SELECT_ENABLE_PIN, POR_OK};  // [RQ21]

	input_sync #(.W(SYNC_W)) u_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.sif   (sif)
	);

	// Named views of the qualified bank.
	assign por_s   = sif.clean[SY_POR];
	assign en_s    = sif.clean[SY_EN];
	assign oc_s    = sif.clean[SY_OC];
	assign ov_s    = sif.clean[SY_OV];
	assign ovref_s = sif.clean[SY_OVREF];
	assign uv_s    = sif.clean[SY_UV];
	assign ph3_s   = sif.clean[SY_PH3];
	assign code_s  = sif.clean[SY_CODE_LSB +: 5];
	assign dem_s   = sif.clean[SY_DEM_LSB +: NCH];

	// One switching cycle is counted on each rising edge of the phase tick.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			tick_d_reg <= 1'b0;
		end else begin
			tick_d_reg <= sif.clean[SY_TICK];
		end
	end
	assign tick = sif.clean[SY_TICK] && !tick_d_reg;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	state_t       state_reg;
	logic [10:0]  cnt_reg;
	logic         ov_latch_reg;
	logic         force_reg;
	logic         hiccup;
	logic         powered;
	logic         run_ok;

	// The POR input comes from a comparator that already has hysteresis.
	assign powered = por_s && en_s;  // [RQ14]
	assign run_ok  = (code_s != CODE_OFF) && !force_reg;  // [RQ7]
	assign hiccup  = oc_s && powered && run_ok && !ov_latch_reg && !ov_s &&
		(state_reg inside {ST_SS_HIZ, ST_SS_LOW, ST_SS_RAMP, ST_RUN});  // [RQ1]

	// Overvoltage latch; only losing POR or dropping the enable pin clears it.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ov_latch_reg <= 1'b0;
		end else if (!powered) begin
			ov_latch_reg <= 1'b0;  // [RQ11]
		end else if (ov_s) begin
			ov_latch_reg <= 1'b1;  // [RQ11]
		end
	end

	// Main state machine; power loss wins, overvoltage next, then the code.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= ST_SHUT;
			cnt_reg   <= '0;
		end else if (!powered) begin
			state_reg <= ST_SHUT;  // [RQ14] [RQ15]
			cnt_reg   <= '0;
		end else if (ov_s) begin
			state_reg <= ST_OV_CLAMP;  // [RQ8] [RQ10]
		end else if (ov_latch_reg) begin
			if (state_reg == ST_OV_CLAMP && ovref_s) begin
				state_reg <= ST_OV_HIZ;  // [RQ9]
			end else if (state_reg != ST_OV_CLAMP) begin
				state_reg <= ST_OV_HIZ;
			end
		end else if (!run_ok) begin
			state_reg <= ST_SHUT;  // [RQ7]
			cnt_reg   <= '0;
		end else if (hiccup) begin
			state_reg <= ST_OC_WAIT;  // [RQ1] [RQ5]
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				ST_SHUT: begin
					state_reg <= ST_SS_HIZ;  // [RQ17]
					cnt_reg   <= '0;
				end
				ST_SS_HIZ: begin
					if (tick) begin
						cnt_reg <= cnt_reg + 11'h001;  // [RQ20]
						if (cnt_reg == SS_HIZ_END) begin
							state_reg <= ST_SS_LOW;  // [RQ19]
						end
					end
				end
				ST_SS_LOW: begin
					if (tick) begin
						cnt_reg <= cnt_reg + 11'h001;
						if (cnt_reg == SS_LOW_END) begin
							state_reg <= ST_SS_RAMP;  // [RQ19]
						end
					end
				end
				ST_SS_RAMP: begin
					if (tick) begin
						cnt_reg <= cnt_reg + 11'h001;
						if (cnt_reg == SS_LAST) begin
							state_reg <= ST_RUN;  // [RQ4] [RQ20]
						end
					end
				end
				ST_RUN: begin
					state_reg <= ST_RUN;
				end
				ST_OC_WAIT: begin
					if (tick) begin
						cnt_reg <= cnt_reg + 11'h001;  // [RQ3]
						if (cnt_reg == OC_WAIT_LAST) begin
							state_reg <= ST_SS_HIZ;  // [RQ4] [RQ5]
						end
					end
				end
				default: begin
					state_reg <= ST_SHUT;
					cnt_reg   <= '0;
				end
			endcase
		end
	end

	// Power good only in normal running, dropped by undervoltage without memory.
	// The off code drops it at once, since the reference goes to zero on that edge.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			POWER_GOOD <= 1'b0;
			OSC_RUN    <= 1'b0;
		end else begin
			POWER_GOOD <= (state_reg == ST_RUN) && run_ok && !uv_s;  // [RQ12] [RQ20]
			OSC_RUN    <= en_s;  // [RQ15]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reference level: decoded code, ramped from zero during soft-start.

	logic [10:0] target_mv;
	always_comb begin
		target_mv = REF_TOP_MV - 11'(code_s) * REF_STEP_MV;  // [RQ6]
		if (code_s == CODE_OFF) begin
			target_mv = '0;  // [RQ7]
		end
	end

	// The ramp steps once per switching cycle so the output capacitors charge slowly.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			REFERENCE_LEVEL <= '0;
		end else if (state_reg == ST_RUN || state_reg inside {ST_OV_CLAMP, ST_OV_HIZ}) begin
			REFERENCE_LEVEL <= target_mv;  // [RQ6]
		end else if (state_reg == ST_SS_RAMP) begin
			if (REFERENCE_LEVEL > target_mv) begin
				REFERENCE_LEVEL <= target_mv;
			end else if (tick && REFERENCE_LEVEL < target_mv) begin
				REFERENCE_LEVEL <= REFERENCE_LEVEL + RAMP_STEP_MV;  // [RQ19]
			end
		end else begin
			REFERENCE_LEVEL <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-channel PWM drive and current balance.

	logic [9:0]        cur_sum;
	logic [17:0]       third_prod;
	logic [CUR_W:0]    avg;

	// A multiply by 171/512 stands in for a divide by three; error under 0.2 percent.
	always_comb begin
		cur_sum    = 10'(CH_CURRENT[0 +: CUR_W]) + 10'(CH_CURRENT[CUR_W +: CUR_W]);
		if (ph3_s) begin
			cur_sum = cur_sum + 10'(CH_CURRENT[2*CUR_W +: CUR_W]);
		end
		third_prod = 18'(cur_sum) * 18'(THIRD_MUL);
		avg        = ph3_s ? 9'(third_prod[17:9]) : 9'(cur_sum[9:1]);  // [RQ18]
	end

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			logic active;
			// With two phases the third output is tied to the supply and never driven.
			assign active = (c < 2) || ph3_s;

			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					PWM_OUT[c] <= 1'b0;
					PWM_OE[c]  <= 1'b0;
				end else begin
					case (state_reg)
						ST_RUN, ST_SS_RAMP: begin
							PWM_OUT[c] <= dem_s[c];  // [RQ4]
							PWM_OE[c]  <= active;
						end
						ST_SS_LOW, ST_OV_CLAMP: begin
							PWM_OUT[c] <= 1'b0;  // [RQ8] [RQ19]
							PWM_OE[c]  <= active;
						end
						default: begin
							PWM_OUT[c] <= 1'b0;  // [RQ2] [RQ9] [RQ13]
							PWM_OE[c]  <= 1'b0;
						end
					endcase
				end
			end

			// Positive trim means the channel carries less than its share.
			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					BALANCE_TRIM[c*ERR_W +: ERR_W] <= '0;
				end else if (active) begin
					BALANCE_TRIM[c*ERR_W +: ERR_W] <= avg - 9'(CH_CURRENT[c*CUR_W +: CUR_W]);  // [RQ18]
				end else begin
					BALANCE_TRIM[c*ERR_W +: ERR_W] <= '0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: write path.

	logic              aw_have_reg;
	logic              w_have_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              wr_go;
	logic [15:0]       oc_count_reg;

	assign wr_go = aw_have_reg && w_have_reg && !S_AXI_BVALID;

	// Address and data are taken independently and paired before the response.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
		end else begin
			S_AXI_AWREADY <= !S_AXI_AWREADY && S_AXI_AWVALID && !aw_have_reg && !S_AXI_BVALID;
			S_AXI_WREADY  <= !S_AXI_WREADY && S_AXI_WVALID && !w_have_reg && !S_AXI_BVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (wr_go) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (aw_addr_reg[4:2] <= OFS_OC_COUNT[4:2]) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Software shutdown request; only byte lane zero carries it.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			force_reg <= CTRL_FORCE_RST;
		end else if (wr_go && aw_addr_reg[4:2] == OFS_CTRL[4:2] && w_strb_reg[0]) begin
			force_reg <= w_data_reg[CTRL_FORCE_BIT];
		end
	end

	// Hiccup counter; a new hiccup wins over a clear in the same cycle.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			oc_count_reg <= '0;
		end else if (hiccup) begin
			oc_count_reg <= oc_count_reg + 16'h0001;
		end else if (wr_go && aw_addr_reg[4:2] == OFS_OC_COUNT[4:2]) begin
			oc_count_reg <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: read path.

	logic [31:0] status_word;
	always_comb begin
		status_word                     = '0;
		status_word[ST_STATE_LSB +: 4]  = 4'(state_reg);
		status_word[ST_PG_BIT]          = POWER_GOOD;
		status_word[ST_OVL_BIT]         = ov_latch_reg;
		status_word[ST_OSC_BIT]         = OSC_RUN;
		status_word[ST_ENOK_BIT]        = powered && run_ok;
		status_word[ST_CODE_LSB +: 5]   = code_s;
		status_word[ST_PH3_BIT]         = ph3_s;
	end

	// Unmapped reads answer SLVERR with zero data.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= '0;
			S_AXI_RRESP   <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_ARREADY && S_AXI_ARVALID && !S_AXI_RVALID;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP  <= RESP_OKAY;
				case (S_AXI_ARADDR[4:2])
					OFS_CTRL[4:2]:     S_AXI_RDATA <= 32'(force_reg);
					OFS_STATUS[4:2]:   S_AXI_RDATA <= status_word;
					OFS_REF[4:2]:      S_AXI_RDATA <= 32'(REFERENCE_LEVEL);
					OFS_OC_COUNT[4:2]: S_AXI_RDATA <= 32'(oc_count_reg);
					default: begin
						S_AXI_RDATA <= '0;
						S_AXI_RRESP <= RESP_SLVERR;
					end
				endcase
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule

// [dv/buck_props.sv]
// Port checker of the buck supervisor, bound to its top module.
// Assumes pin inputs change after clock edges and hold for several cycles.
`timescale 1ns/1ps
module buck_props import buck_pkg::*; (
	// Clock and reset.
	input wire logic        CLK,
	input wire logic        RST_B,
	// Pin inputs.
	input wire logic        POR_OK,
	input wire logic        FREQ_SELECT_ENABLE_PIN,
	input wire logic        OC_TRIP,
	input wire logic        OV_TRIP,
	input wire logic        UV_LOW,
	input wire logic [4:0]  VOLTAGE_CODE,
	// Converter outputs and write response.
	input wire logic [2:0]  PWM_OUT,
	input wire logic [2:0]  PWM_OE,
	input wire logic        POWER_GOOD,
	input wire logic        OSC_RUN,
	input wire logic [10:0] REFERENCE_LEVEL,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic [1:0]  S_AXI_BRESP
);
	// Eight held cycles cover the synchroniser and the state and output registers.
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	oc_hiz_a: assert property ((OC_TRIP && !OV_TRIP)[*8] |-> PWM_OE == 3'h0)
		else $error("pwm driven during overcurrent");
	ov_clamp_a: assert property ((OV_TRIP && POR_OK && FREQ_SELECT_ENABLE_PIN)[*8] |->
		PWM_OE[1:0] == 2'h3 && PWM_OUT == 3'h0) else $error("no clamp on overvoltage");
	code_off_a: assert property ((VOLTAGE_CODE == 5'h1f && !OV_TRIP)[*8] |->
		PWM_OE == 3'h0 && REFERENCE_LEVEL == 11'h000) else $error("off code not obeyed");
	en_off_a: assert property ((!FREQ_SELECT_ENABLE_PIN)[*8] |->
		!OSC_RUN && PWM_OE == 3'h0 && !POWER_GOOD) else $error("running while disabled");
	por_off_a: assert property ((!POR_OK)[*8] |-> PWM_OE == 3'h0 && !POWER_GOOD)
		else $error("running without supply");
	uv_pg_a: assert property (UV_LOW[*8] |-> !POWER_GOOD)
		else $error("power good during undervoltage");
	pg_ref_a: assert property (POWER_GOOD |-> REFERENCE_LEVEL >= 11'h44c &&
		REFERENCE_LEVEL <= 11'h73a && (11'h73a - REFERENCE_LEVEL) % 25 == 0)
		else $error("reference off the code grid");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
endmodule

bind buck_supervisor buck_props u_props (.*);

// [dv/buck_far_side.sv]
// Model of the gate drivers, the processor code pins and the enable switch.
// Assumes the bench changes its requests just after a rising clock edge.
`timescale 1ns/1ps
module buck_far_side (
	// Bench requests.
	input  wire logic [4:0] code_req,
	input  wire logic       code_drive,
	input  wire logic       pull_en_low,
	// Controller side.
	input  wire logic [2:0] pwm_out,
	input  wire logic [2:0] pwm_oe,
	output logic      [4:0] voltage_code,
	output logic            freq_select_enable_pin,
	output logic      [2:0] upper_on,
	output logic      [2:0] lower_on
);
	// Released code pins float up on their pull-ups, which reads as the off code.
	assign voltage_code = code_drive ? code_req : 5'h1f;
	// The switch pulls the pin below threshold; released, the pin floats above it.
	assign freq_select_enable_pin = !pull_en_low;
	// A floating input turns both switches of a driver off.
	assign upper_on = pwm_oe & pwm_out;
	assign lower_on = pwm_oe & ~pwm_out;
endmodule

// [dv/tb.sv]
// Self-checking bench of the buck supervisor.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/1ps
module tb import buck_pkg::*;;
	logic        CLK = 1'b0, RST_B = 1'b0, POR_OK = 1'b0, OC_TRIP = 1'b0, OV_TRIP = 1'b0;
	logic        OV_AT_REF = 1'b0, UV_LOW = 1'b0, PHASE_TICK = 1'b0, PHASE3_SEL = 1'b1;
	logic        en_low = 1'b1, code_on = 1'b0, POWER_GOOD, OSC_RUN;
	logic [4:0]  code = 5'h1e;
	wire  [4:0]  VOLTAGE_CODE;
	wire         FREQ_SELECT_ENABLE_PIN;
	logic [2:0]  PWM_DEMAND = 3'h7, PWM_OUT, PWM_OE, up_on, lo_on;
	logic [23:0] CH_CURRENT = 24'h5a3c1e;
	logic [10:0] REFERENCE_LEVEL;
	logic [26:0] BALANCE_TRIM;
	logic [4:0]  S_AXI_AWADDR = 5'h00, S_AXI_ARADDR = 5'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [3:0]  S_AXI_WSTRB = 4'hf;
	logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY;
	logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	int          error_cnt = 0, n_compared = 0;
	typedef struct packed {
		logic [4:0]  code;
		logic [10:0] mv;
	} row_t;
	row_t rows [4] = '{'{5'h1e, 11'h44c}, '{5'h00, 11'h73a}, '{5'h0f, 11'h5c3}, '{5'h10, 11'h5aa}};

	buck_far_side u_far (.code_req(code), .code_drive(code_on), .pull_en_low(en_low),
		.pwm_out(PWM_OUT), .pwm_oe(PWM_OE), .voltage_code(VOLTAGE_CODE),
		.freq_select_enable_pin(FREQ_SELECT_ENABLE_PIN),
		.upper_on(up_on), .lower_on(lo_on));
	buck_supervisor u_dut (.*);

	////////////////////////////////////////////////////////////
	// Clock, and a phase tick of eight clocks so each level holds four.
	initial forever #2 CLK = ~CLK;
	always begin
		repeat (4) @(posedge CLK);
		PHASE_TICK <= ~PHASE_TICK;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic tk(input int n);
		cyc(n * 8);
	endtask
	// Address and data are released one by one as each is taken; the response is
	// accepted one cycle late, so the slave must hold it through a wait.
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		do begin
			@(posedge CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'b1;
		@(posedge CLK);
		S_AXI_BREADY <= 1'b0;
		chk(S_AXI_BRESP, r);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'b0;
		chk(S_AXI_RDATA & m, e);
		chk(S_AXI_RRESP, r);
	endtask
	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// The whole run takes near 69600 clocks; this limit only cuts a hang.
	initial begin
		cyc(90000);
		error_cnt++;
		finish_test();
	end

	// Main sequence: table of codes in normal running, then the awkward cases.
	initial begin
		cyc(10);
		RST_B <= 1'b1;
		cyc(2);
		chk({POWER_GOOD, OSC_RUN, PWM_OE, REFERENCE_LEVEL}, 32'h0);
		rd(OFS_CTRL, 32'hffffffff, 32'h0, RESP_OKAY);
		S_AXI_WSTRB <= 4'he;
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		S_AXI_WSTRB <= 4'hf;
		rd(OFS_CTRL, 32'hffffffff, 32'h0, RESP_OKAY);
		wr(5'h14, 32'h1, RESP_SLVERR);
		rd(5'h14, 32'hffffffff, 32'h0, RESP_SLVERR);
		en_low <= 1'b0;
		cyc(40);
		chk(PWM_OE, 3'h0);
		rd(OFS_STATUS, 32'hf, 32'h0, RESP_OKAY);
		code_on <= 1'b1;
		POR_OK <= 1'b1;
		tk(20);
		chk(PWM_OE, 3'h0);
		tk(80);
		chk({up_on, lo_on}, 32'h7);
		tk(1930);
		chk(POWER_GOOD, 1'b0);
		tk(30);
		chk(POWER_GOOD, 1'b1);
		$display("done start-up");
		foreach (rows[i]) begin
			code <= rows[i].code;
			cyc(12);
			chk(REFERENCE_LEVEL, rows[i].mv);
			rd(OFS_REF, 32'h7ff, rows[i].mv, RESP_OKAY);
		end
		code <= 5'h1e;
		chk({PWM_OE, BALANCE_TRIM}, {3'h7, 9'h1e2, 9'h000, 9'h01e});
		chk({PWM_OE, PWM_OUT}, 6'h3f);
		PHASE3_SEL <= 1'b0;
		cyc(10);
		chk({PWM_OE, BALANCE_TRIM}, {3'h3, 9'h000, 9'h1f1, 9'h00f});
		PHASE3_SEL <= 1'b1;
		UV_LOW <= 1'b1;
		cyc(10);
		chk({POWER_GOOD, PWM_OE}, 4'h7);
		UV_LOW <= 1'b0;
		cyc(10);
		chk(POWER_GOOD, 1'b1);
		$display("done code table, balance and undervoltage");
		code_on <= 1'b0;
		cyc(10);
		chk({PWM_OE, REFERENCE_LEVEL}, 32'h0);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		code_on <= 1'b1;
		cyc(20);
		rd(OFS_STATUS, 32'hf, 32'h0, RESP_OKAY);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		tk(100);
		OC_TRIP <= 1'b1;
		cyc(10);
		chk({up_on, lo_on}, 32'h0);
		OC_TRIP <= 1'b0;
		rd(OFS_OC_COUNT, 32'hffff, 32'h1, RESP_OKAY);
		tk(2000);
		chk(PWM_OE, 3'h0);
		tk(150);
		chk({PWM_OE, PWM_OUT}, 6'h38);
		OC_TRIP <= 1'b1;
		cyc(10);
		chk(PWM_OE, 3'h0);
		OC_TRIP <= 1'b0;
		rd(OFS_OC_COUNT, 32'hffff, 32'h2, RESP_OKAY);
		wr(OFS_OC_COUNT, 32'h0, RESP_OKAY);
		rd(OFS_OC_COUNT, 32'hffff, 32'h0, RESP_OKAY);
		tk(4150);
		chk(POWER_GOOD, 1'b1);
		$display("done shutdown and hiccup");
		OV_TRIP <= 1'b1;
		cyc(10);
		chk({PWM_OE, lo_on}, 6'h3f);
		OV_TRIP <= 1'b0;
		OV_AT_REF <= 1'b1;
		cyc(10);
		chk(PWM_OE, 3'h0);
		OV_AT_REF <= 1'b0;
		OV_TRIP <= 1'b1;
		cyc(10);
		chk(lo_on, 3'h7);
		OV_TRIP <= 1'b0;
		OV_AT_REF <= 1'b1;
		cyc(10);
		OV_AT_REF <= 1'b0;
		tk(100);
		chk({POWER_GOOD, PWM_OE}, 4'h0);
		rd(OFS_STATUS, 32'h2f, 32'h27, RESP_OKAY);
		en_low <= 1'b1;
		cyc(10);
		chk(OSC_RUN, 1'b0);
		en_low <= 1'b0;
		tk(100);
		chk({PWM_OE, PWM_OUT}, 6'h38);
		rd(OFS_STATUS, 32'h2f, 32'h2, RESP_OKAY);
		POR_OK <= 1'b0;
		cyc(10);
		chk({POWER_GOOD, PWM_OE}, 4'h0);
		$display("done overvoltage and enable");
		finish_test();
	end
endmodule
